// [verilog/rmmb_top.v]
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rmmb_map.vh"

module rmmb_top #(
    parameter SWITCH_CYC = `RMMB_T_SWITCH_US * `RMMB_CLK_MHZ,
    parameter SETTLE_CYC = `RMMB_T_SETTLE_US * `RMMB_CLK_MHZ,
    parameter INIT_CYC   = `RMMB_INIT_CYC,
    parameter TW         = 20
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Mode pins from the host
    input  wire        mode_select_low,
    input  wire        mode_select_high,
    // Busy sources from the data path
    input  wire        tx_pending,
    input  wire        uart_out_pending,
    input  wire        host_feeding,
    // Received packet addressing
    input  wire        rx_pkt_valid,
    input  wire [15:0] rx_pkt_dest,
    input  wire        rx_pkt_bcast,
    // Status and mode outputs
    output reg         busy_n,
    output reg  [1:0]  mode,
    output reg         serial_en,
    output reg         radio_en,
    output reg         wor_en,
    output reg         cfg_access_en,
    output reg         sleep,
    output reg         param_load,
    output reg         tx_broadcast,
    output reg         rx_accept
);

    localparam [1:0] ST_INIT = 2'd0;
    localparam [1:0] ST_RUN  = 2'd1;
    localparam [1:0] ST_WAIT = 2'd2;

    localparam [31:0]   SW_W   = SWITCH_CYC;
    localparam [31:0]   SET_W  = SETTLE_CYC;
    localparam [31:0]   INIT_W = INIT_CYC;
    // Counts cut to the timer width on purpose; TW must be wide enough to hold them
    localparam [TW-1:0] SW_V   = SW_W[TW-1:0];
    localparam [TW-1:0] SET_V  = SET_W[TW-1:0];
    localparam [TW-1:0] INIT_V = INIT_W[TW-1:0];

    // Synchronised mode pins
    wire [1:0] pins;

    rmmb_sync #(
        .W (2)
    ) u_pin_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({mode_select_high, mode_select_low}),
        .q       (pins)
    );

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [1:0]  mode_d;
    reg  [1:0]  pend_q;
    reg  [1:0]  pend_d;
    reg         start_q;
    reg         start_d;
    reg  [15:0] own_addr_q;
    reg         busy_n_d;
    reg         sw_load;
    reg  [TW-1:0] sw_value;

    wire        sw_running;
    wire        sw_fire;
    wire        settle_running;
    wire        settle_load;
    wire        src_busy;
    wire        own_special;

    // Any pending data path work keeps the module busy
    assign src_busy    = tx_pending | uart_out_pending | host_feeding;
    assign own_special = (own_addr_q == `RMMB_ADDR_ALL_ONE) ||
                         (own_addr_q == `RMMB_ADDR_ALL_ZERO);

    // Self-check, reload and switch delays share one timer
    rmmb_timer #(
        .TW (TW)
    ) u_sw_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (sw_load),
        .value   (sw_value),
        .running (sw_running),
        .fire    (sw_fire)
    );

    // Measures how long busy has stood high since its rising edge
    assign settle_load = busy_n_d && !busy_n;

    rmmb_timer #(
        .TW (TW)
    ) u_settle_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (settle_load),
        .value   (SET_V),
        .running (settle_running),
        .fire    ()
    );

    always @* begin
        state_d  = state_q;
        mode_d   = mode;
        pend_d   = pend_q;
        start_d  = 1'b0;
        sw_load  = 1'b0;
        sw_value = SW_V;
        case (state_q)
            ST_INIT: begin
                if (start_q) begin
                    sw_load  = 1'b1;
                    sw_value = INIT_V;
                end else if (!sw_running) begin
                    // Pins are only looked at once the sequence is over
                    mode_d  = pins;
                    pend_d  = pins;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // Busy blocks any look at the pins
                if (!src_busy && (pins != mode)) begin
                    pend_d  = pins;
                    sw_load = 1'b1;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (src_busy) begin
                    // New data arrived; the request is dropped and re-examined later
                    state_d = ST_RUN;
                end else if (pins != pend_q) begin
                    pend_d  = pins;
                    sw_load = 1'b1;
                    if (pins == mode) begin
                        state_d = ST_RUN;
                    end
                end else if (!sw_running && !settle_running) begin
                    // Applies at the later of 1ms after the request and 2ms after rise
                    mode_d = pend_q;
                    if (mode == `RMMB_MODE_SLEEP) begin
                        start_d = 1'b1;
                        state_d = ST_INIT;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            default: begin
                state_d = ST_INIT;
                start_d = 1'b1;
            end
        endcase
    end

    always @* begin
        // Low wins: any source or the reload sequence pulls busy low
        busy_n_d = (state_d != ST_INIT) && !src_busy;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= ST_INIT;
            start_q    <= 1'b1;
            pend_q     <= `RMMB_MODE_NORMAL;
            mode       <= `RMMB_MODE_NORMAL;
            busy_n     <= 1'b0;
            param_load <= 1'b0;
        end else begin
            state_q    <= state_d;
            start_q    <= start_d;
            pend_q     <= pend_d;
            mode       <= mode_d;
            busy_n     <= busy_n_d;
            param_load <= start_q;
        end
    end

    // Mode decode into path enables; all off while the sequence runs
    reg         serial_en_d;
    reg         radio_en_d;
    reg         wor_en_d;
    reg         cfg_en_d;
    reg         sleep_d;

    always @* begin
        serial_en_d = 1'b0;
        radio_en_d  = 1'b0;
        wor_en_d    = 1'b0;
        cfg_en_d    = 1'b0;
        sleep_d     = 1'b0;
        if (state_d != ST_INIT) begin
            case (mode_d)
                `RMMB_MODE_NORMAL: begin
                    // Serial and radio both open for transparent transfer
                    serial_en_d = 1'b1;
                    radio_en_d  = 1'b1;
                end
                `RMMB_MODE_WOR: begin
                    serial_en_d = 1'b1;
                    radio_en_d  = 1'b1;
                    wor_en_d    = 1'b1;
                end
                `RMMB_MODE_CONFIG: begin
                    // Radio off so no air traffic disturbs register access
                    serial_en_d = 1'b1;
                    cfg_en_d    = 1'b1;
                end
                default: begin
                    sleep_d     = 1'b1;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_en     <= 1'b0;
            radio_en      <= 1'b0;
            wor_en        <= 1'b0;
            cfg_access_en <= 1'b0;
            sleep         <= 1'b0;
        end else begin
            serial_en     <= serial_en_d;
            radio_en      <= radio_en_d;
            wor_en        <= wor_en_d;
            cfg_access_en <= cfg_en_d;
            sleep         <= sleep_d;
        end
    end

    // Address filtering
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_broadcast <= 1'b0;
            rx_accept    <= 1'b0;
        end else begin
            tx_broadcast <= own_special;
            rx_accept    <= rx_pkt_valid && radio_en &&
                            (own_special || rx_pkt_bcast ||
                             (rx_pkt_dest == own_addr_q));
        end
    end

    // AHB-Lite slave, zero wait states
    reg                   wr_pend_q;
    reg [`RMMB_OFS_W-1:0] wr_addr_q;
    reg [31:0]            rdata_d;
    reg [15:0]            own_now;

    wire ap_valid = hsel && htrans[1] && hready;
    wire [`RMMB_OFS_W-1:0] ap_addr = haddr[`RMMB_OFS_W-1:0];
    wire ctrl_wr  = wr_pend_q && (wr_addr_q == `RMMB_OFS_CTRL);

    always @* begin
        // Forward a write still in its data phase to a read right behind it
        own_now = ctrl_wr ? hwdata[`RMMB_CTRL_ADDR_MSB:`RMMB_CTRL_ADDR_LSB] : own_addr_q;
        rdata_d = 32'h0000_0000;
        case (ap_addr)
            `RMMB_OFS_CTRL: begin
                rdata_d[`RMMB_CTRL_ADDR_MSB:`RMMB_CTRL_ADDR_LSB] = own_now;
            end
            `RMMB_OFS_STATUS: begin
                rdata_d[`RMMB_ST_MODE_MSB:`RMMB_ST_MODE_LSB] = mode;
                rdata_d[`RMMB_ST_BUSY_N]                     = busy_n;
                rdata_d[`RMMB_ST_FSM_MSB:`RMMB_ST_FSM_LSB]   = state_q;
                rdata_d[`RMMB_ST_PINS_MSB:`RMMB_ST_PINS_LSB] = pins;
                rdata_d[`RMMB_ST_PEND_MSB:`RMMB_ST_PEND_LSB] = pend_q;
                rdata_d[`RMMB_ST_SETTLED]                    = !settle_running;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= {`RMMB_OFS_W{1'b0}};
            own_addr_q <= `RMMB_OWN_ADDR_RST;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wr_pend_q <= ap_valid && hwrite;
            if (ap_valid) begin
                wr_addr_q <= ap_addr;
            end
            if (ctrl_wr) begin
                own_addr_q <= hwdata[`RMMB_CTRL_ADDR_MSB:`RMMB_CTRL_ADDR_LSB];
            end
            if (ap_valid && !hwrite) begin
                hrdata <= rdata_d;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule // rmmb_top

`default_nettype wire

// [verilog/rmmb_map.vh]
`ifndef RMMB_MAP_VH
`define RMMB_MAP_VH

// Register byte offsets on the AHB-Lite bus
`define RMMB_OFS_CTRL       8'h00
`define RMMB_OFS_STATUS     8'h04
`define RMMB_OFS_W          8

// Control register: own module address
`define RMMB_CTRL_ADDR_LSB  0
`define RMMB_CTRL_ADDR_MSB  15
`define RMMB_OWN_ADDR_RST   16'h0000
`define RMMB_ADDR_ALL_ONE   16'hffff
`define RMMB_ADDR_ALL_ZERO  16'h0000

// Status register fields
`define RMMB_ST_MODE_LSB    0
`define RMMB_ST_MODE_MSB    1
`define RMMB_ST_BUSY_N      2
`define RMMB_ST_FSM_LSB     3
`define RMMB_ST_FSM_MSB     4
`define RMMB_ST_PINS_LSB    5
`define RMMB_ST_PINS_MSB    6
`define RMMB_ST_PEND_LSB    7
`define RMMB_ST_PEND_MSB    8
`define RMMB_ST_SETTLED     9

// Modes as {mode_select_high, mode_select_low}
`define RMMB_MODE_NORMAL    2'b00
`define RMMB_MODE_WOR       2'b01
`define RMMB_MODE_CONFIG    2'b10
`define RMMB_MODE_SLEEP     2'b11

// Timing
`define RMMB_CLK_MHZ        200
`define RMMB_T_SWITCH_US    1000
`define RMMB_T_SETTLE_US    2000
`define RMMB_INIT_CYC       64

`endif

// [verilog/rmmb_sync.v]
`timescale 1ns/1ps
`default_nettype none

module rmmb_sync #(
    parameter W = 2
) (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // rmmb_sync

`default_nettype wire

// [verilog/rmmb_timer.v]
`timescale 1ns/1ps
`default_nettype none

module rmmb_timer #(
    parameter TW = 20
) (
    // Clock and reset
    input  wire          hclk,
    input  wire          hresetn,
    // Control
    input  wire          load,
    input  wire [TW-1:0] value,
    // Status
    output wire          running,
    output wire          fire
);

    reg [TW-1:0] cnt_q;
    reg [TW-1:0] cnt_d;

    always @* begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != {TW{1'b0}}) begin
            cnt_d = cnt_q - {{(TW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= {TW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign running = (cnt_q != {TW{1'b0}});
    // Last cycle of the count; a reload in that cycle cancels it
    assign fire    = (cnt_q == {{(TW-1){1'b0}}, 1'b1}) && !load;

endmodule // rmmb_timer

`default_nettype wire

// [sim/rmmb_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rmmb_top_monitor #(
    parameter SWITCH_CYC = 20,
    parameter SETTLE_CYC = 40
) (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Host side inputs
    input wire logic       mode_select_low,
    input wire logic       mode_select_high,
    input wire logic       tx_pending,
    input wire logic       uart_out_pending,
    input wire logic       host_feeding,
    input wire logic       rx_pkt_valid,
    input wire logic       rx_pkt_bcast,
    // Block outputs
    input wire logic       busy_n,
    input wire logic [1:0] mode,
    input wire logic       serial_en,
    input wire logic       radio_en,
    input wire logic       wor_en,
    input wire logic       cfg_access_en,
    input wire logic       sleep,
    input wire logic       param_load,
    input wire logic       rx_accept
);
    wire       src  = tx_pending | uart_out_pending | host_feeding;
    wire [1:0] pins = {mode_select_high, mode_select_low};
    logic [1:0] pins_q;
    int         cnt_q;
    // Idle cycles spent with a steady request that differs from the mode
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_q <= 2'h0;
            cnt_q  <= 0;
        end else begin
            pins_q <= pins;
            if (!busy_n || pins == mode || pins != pins_q) cnt_q <= 0;
            else cnt_q <= cnt_q + 1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_busy_source: assert property (src |=> !busy_n)
        else $error("busy_n high with a busy source");
    a_init_low: assert property (param_load |=> !busy_n [*6])
        else $error("busy_n rose during self-check");
    a_load_pulse: assert property (param_load |=> !param_load)
        else $error("param_load longer than one cycle");
    a_mode_frozen: assert property (busy_n ##1 src [*3] |-> $stable(mode))
        else $error("mode changed while busy");
    a_mode_decode: assert property (busy_n && $past(busy_n) && $stable(mode) |->
        radio_en == !mode[1] && serial_en == (mode != 2'b11) && wor_en == (mode == 2'b01)
        && cfg_access_en == (mode == 2'b10) && sleep == (mode == 2'b11))
        else $error("enables disagree with mode");
    a_rx_bcast: assert property (rx_pkt_valid && rx_pkt_bcast && radio_en |=> rx_accept)
        else $error("broadcast packet not accepted");
    a_rx_quiet: assert property (!rx_pkt_valid |=> !rx_accept)
        else $error("accept without a packet");
    a_switch_early: assert property ($changed(mode) && $past(busy_n) && busy_n |->
        $past(cnt_q) >= SWITCH_CYC - 2)
        else $error("mode switched too early");
    a_switch_late: assert property (cnt_q <= SWITCH_CYC + SETTLE_CYC + 8)
        else $error("mode switch overdue");
endmodule // rmmb_top_monitor
bind rmmb_top rmmb_top_monitor #(.SWITCH_CYC(SWITCH_CYC), .SETTLE_CYC(SETTLE_CYC)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .mode_select_low(mode_select_low),
    .mode_select_high(mode_select_high), .tx_pending(tx_pending),
    .uart_out_pending(uart_out_pending), .host_feeding(host_feeding),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_bcast(rx_pkt_bcast), .busy_n(busy_n), .mode(mode),
    .serial_en(serial_en), .radio_en(radio_en), .wor_en(wor_en),
    .cfg_access_en(cfg_access_en), .sleep(sleep), .param_load(param_load),
    .rx_accept(rx_accept));
`default_nettype wire

// [sim/rmmb_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rmmb_host (
    // Clock and status
    input  wire logic hclk,
    input  wire logic busy_n,
    // Mode pins and data-path activity
    output var logic  mode_select_low,
    output var logic  mode_select_high,
    output var logic  tx_pending,
    output var logic  uart_out_pending,
    output var logic  host_feeding
);
    initial {mode_select_high, mode_select_low, tx_pending, uart_out_pending, host_feeding} = 0;
    task automatic set_pins(input logic [1:0] m);
        @(posedge hclk);
        {mode_select_high, mode_select_low} <= m;
    endtask
    task automatic set_busy(input logic [2:0] s);
        @(posedge hclk);
        {tx_pending, uart_out_pending, host_feeding} <= s;
    endtask
    // A busy_n seen high in any sampled cycle means the module is up
    task automatic wait_ready(input int lim, output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < lim && !ok; n++) begin
            @(posedge hclk);
            ok = (busy_n === 1'b1);
        end
    endtask
endmodule // rmmb_host
`default_nettype wire

// [sim/test_rmmb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_rmmb_top;
    localparam int SW = 20;
    localparam int ST = 40;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_pkt_valid = 0, rx_pkt_bcast = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [15:0] rx_pkt_dest = 0;
    logic [1:0]  htrans = 0, mode;
    logic [2:0]  hsize = 3'h2;
    logic        hs = 1'b1;
    logic hreadyout, hresp, msl, msh, txp, uop, hf, busy_n, serial_en, radio_en, wor_en;
    logic cfg_access_en, sleep, param_load, tx_broadcast, rx_accept, ok, sp;
    int err_count = 0, checks = 0, cyc = 0, loads = 0;
    logic [31:0] av[3] = '{32'h1234, 32'hdeadffff, 32'h0};
    logic [1:0]  ml[3] = '{2'h1, 2'h2, 2'h0};
    logic [4:0]  en[3] = '{5'h1c, 5'h0a, 5'h18};
    logic [2:0]  bs[3] = '{3'h4, 3'h2, 3'h1};
    always #2.5 hclk = ~hclk;
    rmmb_top #(.SWITCH_CYC(SW), .SETTLE_CYC(ST), .INIT_CYC(8)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mode_select_low(msl), .mode_select_high(msh),
        .tx_pending(txp), .uart_out_pending(uop), .host_feeding(hf), .rx_pkt_valid(rx_pkt_valid),
        .rx_pkt_dest(rx_pkt_dest), .rx_pkt_bcast(rx_pkt_bcast), .busy_n(busy_n), .mode(mode),
        .serial_en(serial_en), .radio_en(radio_en), .wor_en(wor_en),
        .cfg_access_en(cfg_access_en), .sleep(sleep), .param_load(param_load),
        .tx_broadcast(tx_broadcast), .rx_accept(rx_accept));
    rmmb_host u_host (.hclk(hclk), .busy_n(busy_n), .mode_select_low(msl),
        .mode_select_high(msh), .tx_pending(txp), .uart_out_pending(uop), .host_feeding(hf));
    always @(posedge hclk) begin
        if (param_load === 1'b1) loads <= loads + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= hs;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rx(input logic [15:0] d, input logic b, input logic e);
        rx_pkt_valid <= 1'b1;
        rx_pkt_dest  <= d;
        rx_pkt_bcast <= b;
        @(posedge hclk);
        rx_pkt_valid <= 1'b0;
        @(posedge hclk);
        check(32'(rx_accept), 32'(e));
    endtask
    // Elapsed cycles until the mode shows m must fall in [lo, hi]
    task automatic wait_mode(input logic [1:0] m, input int lo, input int hi);
        int n;
        n = 0;
        while (mode !== m && n <= hi) begin
            @(posedge hclk);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(32'(busy_n), 32'h0);
        u_host.wait_ready(40, ok);
        check(32'(ok), 32'h1);
        ahb(1'b0, 32'h4, 32'h0);
        check(r & 32'h7, 32'h4);
        check(32'(tx_broadcast), 32'h1);
        $display("test reset done");
        foreach (av[i]) begin
            ahb(1'b1, 32'h0, av[i]);
            ahb(1'b0, 32'h0, 32'h0);
            check(r, av[i] & 32'hffff);
            sp = (av[i][15:0] == 16'hffff || av[i][15:0] == 16'h0);
            check(32'(tx_broadcast), 32'(sp));
            rx(16'h1234, 1'b0, sp || av[i][15:0] == 16'h1234);
            rx(16'h5678, 1'b0, sp);
            rx(16'h9abc, 1'b1, 1'b1);
        end
        ahb(1'b1, 32'h8, 32'h5a5a5a5a);
        ahb(1'b0, 32'h8, 32'h0);
        check(r, 32'h0);
        // A write with the slave deselected must not reach the own address
        hs = 1'b0;
        ahb(1'b1, 32'h0, 32'h4321);
        hs = 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        check(r, 32'h0);
        check(32'(tx_broadcast), 32'h1);
        $display("test address done");
        repeat (ST) @(posedge hclk);
        foreach (ml[i]) begin
            u_host.set_pins(ml[i]);
            wait_mode(ml[i], SW, SW + 10);
            repeat (3) @(posedge hclk);
            check(32'({radio_en, serial_en, wor_en, cfg_access_en, sleep}), 32'(en[i]));
        end
        check(32'(loads), 32'h1);
        $display("test modes done");
        foreach (bs[i]) begin
            u_host.set_busy(bs[i]);
            repeat (3) @(posedge hclk);
            check(32'(busy_n), 32'h0);
            u_host.set_pins(ml[i]);
            repeat (SW + ST) @(posedge hclk);
            check(32'(mode), 32'(ml[(i + 2) % 3]));
            u_host.set_busy(3'h0);
            u_host.wait_ready(10, ok);
            check(32'(ok), 32'h1);
            wait_mode(ml[i], ST - 3, ST + SW + 10);
        end
        $display("test busy done");
        u_host.set_busy(3'h4);
        u_host.set_pins(2'h3);
        repeat (20) @(posedge hclk);
        check(32'(mode), 32'h0);
        u_host.set_busy(3'h0);
        wait_mode(2'h3, 0, ST + SW + 10);
        repeat (3) @(posedge hclk);
        check(32'(sleep), 32'h1);
        u_host.set_pins(2'h0);
        wait_mode(2'h0, SW, SW + 10);
        repeat (3) @(posedge hclk);
        check(32'(busy_n), 32'h0);
        u_host.wait_ready(40, ok);
        check(32'(ok), 32'h1);
        check(32'(loads), 32'h2);
        $display("test sleep done");
        stop_test();
    end
endmodule // test_rmmb_top
`default_nettype wire
